// file: hw/fcs_pkg.sv
// constants shared by the flash configuration and status block
package fcs_pkg;

	// system clock and self-timed status write cycle
	localparam int CLK_PERIOD_NS        = 10;
	localparam int STATUS_WRITE_TIME_NS = 1000;
	localparam int STATUS_WRITE_CYC     =
		(STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// opcodes, plain defaults for this block
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] OP_READ_CONFIG  = 8'h15;
	localparam logic [7:0] OP_ENTER_WIDE   = 8'hb7;
	localparam logic [7:0] OP_EXIT_WIDE    = 8'he9;

	// frame lengths in serial clocks, opcode included
	localparam logic [4:0] FRAME_CMD_ONLY  = 5'h08;
	localparam logic [4:0] FRAME_WR_SHORT  = 5'h10;
	localparam logic [4:0] FRAME_WR_LONG   = 5'h18;
	localparam logic [4:0] FRAME_CNT_MAX   = 5'h1f;

	// status register field positions
	localparam int SR_LOCK_BIT = 7;
	localparam int SR_QE_BIT   = 6;
	localparam int SR_BP_LSB   = 2;
	localparam int SR_WEL_BIT  = 1;
	localparam int SR_WIP_BIT  = 0;

	// configuration register field positions
	localparam int CR_DC_LSB     = 6;
	localparam int CR_AW_BIT     = 5;
	localparam int CR_ORIGIN_BIT = 3;
	localparam int CR_ODS_LSB    = 0;

	// values after reset
	localparam logic [2:0] ODS_RESET    = 3'h7;
	localparam logic [1:0] DC_RESET     = 2'h0;
	localparam logic [3:0] BP_RESET     = 4'h0;
	localparam logic       ORIGIN_RESET = 1'h0;
	localparam logic       AW_RESET     = 1'h0;

	// dummy clocks per dummy_count_sel code, four nibbles, code 3 on top
	localparam logic [15:0] DUMMY_FAST_TBL    = 16'ha868;
	localparam logic [15:0] DUMMY_DUAL_IO_TBL = 16'ha864;
	localparam logic [15:0] DUMMY_QUAD_IO_TBL = 16'ha846;

endpackage

// file: hw/fcs_sync.sv
// two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module fcs_sync #(
	parameter int               WIDTH   = 1,
	// value after reset, set to the idle level of the source
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset of the receiving domain
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// level in, synchronised level out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// first stage is read only by the second
	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;

endmodule
`default_nettype wire

// file: hw/fcs_top.sv
// serial flash configuration register and write-status logic
//
// Overview of operation
// - drive_strength_sel is volatile bits 2:0, default code 111 means 30 ohm
// - drive strength and origin change only through write_status_cmd
// - protect_area_origin at bit 3: 0 protects top, 1 protects bottom
// - addr_width_flag bit 5: enter sets it, exit or power-off clears it
// - dummy_count_sel bits 7:6 selects dummy clocks per read kind, default 00
// - write_status_cmd needs write_latch_flag set by write_enable_cmd first
// - write_status_cmd writes lock, quad enable, protect levels; the 16-bit data form also writes configuration
// - select must rise after exactly 8 or 16 data bits, else rejected
// - self-timed write cycle starts at the closing select rise
// - op_in_progress reads 1 during cycle, then clears with write latch
// - lock set and protect pin low refuses every status write unless quad_io_enable or quad_command_mode is set
// - hw_protect_mode when lock set and pin low, whichever came last
// - hw_protect_mode ends when protect pin goes high or quad_io_enable or quad_command_mode is set
// - quad_io_enable or quad_command_mode disables hardware protection
// - otherwise sw_protect_mode: write enable allows protection bit change
// - program or erase into the protected area is refused in both modes
// - status layout: lock 7, quad 6, levels 5:2, latch 1, busy 0
// - configuration reads are answered at any time, even when busy
// - device reset also clears addr_width_flag
`timescale 1ns/1ps
`default_nettype none
module fcs_top
	import fcs_pkg::*;
#(
	parameter int BLK_W = 9
) (
	// system clock and reset
	input  wire logic             I_CLOCK,
	input  wire logic             I_RST_N,
	// serial link
	input  wire logic             I_SCLK,
	input  wire logic             I_CS_N,
	input  wire logic             I_SI,
	output logic                  O_SO,
	output logic                  O_SO_OE_N,
	// protection pin and mode inputs
	input  wire logic             I_IO2_PIN_N,
	input  wire logic             I_QUAD_COMMAND_MODE,
	// program or erase area check
	input  wire logic             I_PE_REQ,
	input  wire logic [BLK_W-1:0] I_PE_BLOCK,
	output logic                  O_PE_GRANT,
	output logic                  O_PE_REFUSE,
	// configuration and status views
	output logic [2:0]            O_DRIVE_STRENGTH_SEL,
	output logic [1:0]            O_DUMMY_COUNT_SEL,
	output logic [3:0]            O_DUMMY_FAST,
	output logic [3:0]            O_DUMMY_DUAL_IO,
	output logic [3:0]            O_DUMMY_QUAD_IO,
	output logic                  O_ADDR_WIDTH_FLAG,
	output logic                  O_PROTECT_AREA_ORIGIN,
	output logic [7:0]            O_STATUS,
	output logic                  O_HW_PROTECT_MODE,
	output logic                  O_SW_PROTECT_MODE
);

	import fcs_pkg::*;

	// nibble lookup shared by the three dummy tables
	function automatic logic [3:0] dummy_of(input logic [15:0] tbl,
		input logic [1:0] code);
		dummy_of = tbl[{code, 2'h0} +: 4];
	endfunction

	// link side state, clocked by the serial clock
	logic        armed_reg;
	logic        armed_next;
	logic [4:0]  bit_cnt_reg;
	logic [4:0]  bit_cnt_next;
	logic [23:0] shift_reg;
	logic [23:0] shift_next;
	logic [7:0]  opcode_reg;
	logic [7:0]  opcode_next;
	logic        so_reg;
	logic        so_next;
	logic        oe_n_reg;
	logic        oe_n_next;
	logic [15:0] regs_lk;
	logic [7:0]  rd_byte;
	logic        reading;

	// system side state
	logic        cs_sync;
	logic        wp_sync;
	logic        cs_q_reg;
	logic        cs_q_next;
	logic [7:0]  status;
	logic [7:0]  config_view;
	logic        lock_reg;
	logic        lock_next;
	logic        qe_reg;
	logic        qe_next;
	logic [3:0]  bp_reg;
	logic [3:0]  bp_next;
	logic        wel_reg;
	logic        wel_next;
	logic        wip_reg;
	logic        wip_next;
	logic [2:0]  ods_reg;
	logic [2:0]  ods_next;
	logic [1:0]  dc_reg;
	logic [1:0]  dc_next;
	logic        origin_reg;
	logic        origin_next;
	logic        aw_reg;
	logic        aw_next;
	logic [7:0]  pend_sr_reg;
	logic [7:0]  pend_sr_next;
	logic [7:0]  pend_cr_reg;
	logic [7:0]  pend_cr_next;
	logic        pend_cr_ok_reg;
	logic        pend_cr_ok_next;
	logic [15:0] tw_cnt_reg;
	logic [15:0] tw_cnt_next;
	logic        grant_reg;
	logic        grant_next;
	logic        refuse_reg;
	logic        refuse_next;
	logic        cs_rise;
	logic        hw_protect;
	logic        wr_len_ok;
	logic        blk_hit;

	// frame bit counter, shifter and opcode capture
	always_comb begin
		armed_next   = 1'h0;
		bit_cnt_next = bit_cnt_reg;
		if (armed_reg) begin
			bit_cnt_next = 5'h01;
		end else if (bit_cnt_reg != FRAME_CNT_MAX) begin
			bit_cnt_next = bit_cnt_reg + 5'h01;
		end
		shift_next  = {shift_reg[22:0], I_SI};
		opcode_next = opcode_reg;
		if (bit_cnt_next == FRAME_CMD_ONLY) begin
			opcode_next = shift_next[7:0];
		end
	end

	// select high re-arms the counter; serial clock is idle then
	always_ff @(posedge I_SCLK or posedge I_CS_N or negedge I_RST_N) begin
		if (!I_RST_N) begin
			armed_reg <= 1'h1;
		end else if (I_CS_N) begin
			armed_reg <= 1'h1;
		end else begin
			armed_reg <= armed_next;
		end
	end

	always_ff @(posedge I_SCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bit_cnt_reg <= 5'h00;
			shift_reg   <= 24'h000000;
			opcode_reg  <= 8'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
			opcode_reg  <= opcode_next;
		end
	end

	// register images brought over bit by bit; opcode gives 8 clocks to settle
	fcs_sync #(
		.WIDTH (16)
	) u_sync_regs (
		.i_clk   (I_SCLK),
		.i_rst_n (I_RST_N),
		.i_async ({status, config_view}),
		.o_sync  (regs_lk)
	);

	// read answers, shifted out msb first on the falling edge
	// config read always
	always_comb begin
		reading = !armed_reg && (bit_cnt_reg >= FRAME_CMD_ONLY) &&
			(opcode_reg == OP_READ_STATUS ||
			opcode_reg == OP_READ_CONFIG);
		rd_byte = (opcode_reg == OP_READ_STATUS) ? regs_lk[15:8] :
			regs_lk[7:0];
		so_next   = reading ? rd_byte[3'h7 - bit_cnt_reg[2:0]] : 1'h0;
		oe_n_next = !reading;
	end

	always_ff @(negedge I_SCLK or posedge I_CS_N or negedge I_RST_N) begin
		if (!I_RST_N) begin
			oe_n_reg <= 1'h1;
		end else if (I_CS_N) begin
			oe_n_reg <= 1'h1;
		end else begin
			oe_n_reg <= oe_n_next;
		end
	end

	always_ff @(negedge I_SCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			so_reg <= 1'h0;
		end else begin
			so_reg <= so_next;
		end
	end

	// both pins idle high; a low reset value would fake a select rise
	fcs_sync #(
		.WIDTH   (2),
		.RST_VAL (2'h3)
	) u_sync_pins (
		.i_clk   (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_async ({I_CS_N, I_IO2_PIN_N}),
		.o_sync  ({cs_sync, wp_sync})
	);

	// link state is frozen while select is high, so it is read here
	always_comb begin
		cs_q_next = cs_sync;
		cs_rise   = cs_sync && !cs_q_reg;
		hw_protect = lock_reg && !wp_sync &&
			!(qe_reg || I_QUAD_COMMAND_MODE);
		wr_len_ok = (bit_cnt_reg == FRAME_WR_SHORT) ||
			(bit_cnt_reg == FRAME_WR_LONG);
	end

	// command execution and self-timed write cycle
	always_comb begin
		lock_next       = lock_reg;
		qe_next         = qe_reg;
		bp_next         = bp_reg;
		wel_next        = wel_reg;
		wip_next        = wip_reg;
		ods_next        = ods_reg;
		dc_next         = dc_reg;
		origin_next     = origin_reg;
		aw_next         = aw_reg;
		pend_sr_next    = pend_sr_reg;
		pend_cr_next    = pend_cr_reg;
		pend_cr_ok_next = pend_cr_ok_reg;
		tw_cnt_next     = tw_cnt_reg;
		if (wip_reg) begin
			if (tw_cnt_reg != 16'h0000) begin
				tw_cnt_next = tw_cnt_reg - 16'h0001;
			end else begin
				// cycle end clears busy and latch
				wip_next = 1'h0;
				wel_next = 1'h0;
				lock_next = pend_sr_reg[SR_LOCK_BIT];
				qe_next   = pend_sr_reg[SR_QE_BIT];
				bp_next   = pend_sr_reg[SR_BP_LSB +: 4];
				if (pend_cr_ok_reg) begin
					ods_next = pend_cr_reg[CR_ODS_LSB +: 3];
					dc_next  = pend_cr_reg[CR_DC_LSB +: 2];
					origin_next = origin_reg ||
						pend_cr_reg[CR_ORIGIN_BIT];
				end
			end
		end else if (cs_rise) begin
			if (bit_cnt_reg == FRAME_CMD_ONLY) begin
				if (opcode_reg == OP_WRITE_ENABLE) begin
					wel_next = 1'h1;
				end else if (opcode_reg == OP_ENTER_WIDE) begin
					aw_next = 1'h1;
				end else if (opcode_reg == OP_EXIT_WIDE) begin
					aw_next = 1'h0;
				end
			end
			if (opcode_reg == OP_WRITE_STATUS && wr_len_ok &&
				wel_reg && !hw_protect) begin
				wip_next    = 1'h1;
				tw_cnt_next = 16'(STATUS_WRITE_CYC - 1);
				pend_cr_ok_next = (bit_cnt_reg == FRAME_WR_LONG);
				pend_cr_next    = shift_reg[7:0];
				pend_sr_next    = pend_cr_ok_next ? shift_reg[15:8] :
					shift_reg[7:0];
			end
		end
	end

	// reset clears wide flag and volatile state
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cs_q_reg       <= 1'h1;
			lock_reg       <= 1'h0;
			qe_reg         <= 1'h0;
			bp_reg         <= BP_RESET;
			wel_reg        <= 1'h0;
			wip_reg        <= 1'h0;
			ods_reg        <= ODS_RESET;
			dc_reg         <= DC_RESET;
			origin_reg     <= ORIGIN_RESET;
			aw_reg         <= AW_RESET;
			pend_sr_reg    <= 8'h00;
			pend_cr_reg    <= 8'h00;
			pend_cr_ok_reg <= 1'h0;
			tw_cnt_reg     <= 16'h0000;
		end else begin
			cs_q_reg       <= cs_q_next;
			lock_reg       <= lock_next;
			qe_reg         <= qe_next;
			bp_reg         <= bp_next;
			wel_reg        <= wel_next;
			wip_reg        <= wip_next;
			ods_reg        <= ods_next;
			dc_reg         <= dc_next;
			origin_reg     <= origin_next;
			aw_reg         <= aw_next;
			pend_sr_reg    <= pend_sr_next;
			pend_cr_reg    <= pend_cr_next;
			pend_cr_ok_reg <= pend_cr_ok_next;
			tw_cnt_reg     <= tw_cnt_next;
		end
	end

	// protected span is 2^(level-1) blocks from the chosen end
	// area check, both modes
	always_comb begin
		blk_hit = 1'h0;
		for (int i = 0; i < (1 << BLK_W); i++) begin
			if (bp_reg != 4'h0 && I_PE_BLOCK == BLK_W'(i)) begin
				if (origin_reg) begin
					blk_hit = (i >> (int'(bp_reg) - 1)) == 0;
				end else begin
					blk_hit = (((1 << BLK_W) - 1 - i) >>
						(int'(bp_reg) - 1)) == 0;
				end
			end
		end
		grant_next  = I_PE_REQ && !blk_hit;
		refuse_next = I_PE_REQ && blk_hit;
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			grant_reg  <= 1'h0;
			refuse_reg <= 1'h0;
		end else begin
			grant_reg  <= grant_next;
			refuse_reg <= refuse_next;
		end
	end

	always_comb begin
		status = {lock_reg, qe_reg, bp_reg, wel_reg, wip_reg};
		config_view = {dc_reg, aw_reg, 1'h0, origin_reg, ods_reg};
	end

	// software mode whenever hardware mode is off
	assign O_HW_PROTECT_MODE     = hw_protect;
	assign O_SW_PROTECT_MODE     = !hw_protect;
	assign O_SO                  = so_reg;
	assign O_SO_OE_N             = oe_n_reg;
	assign O_PE_GRANT            = grant_reg;
	assign O_PE_REFUSE           = refuse_reg;
	assign O_DRIVE_STRENGTH_SEL  = ods_reg;
	assign O_DUMMY_COUNT_SEL     = dc_reg;
	assign O_DUMMY_FAST          = dummy_of(DUMMY_FAST_TBL, dc_reg);
	assign O_DUMMY_DUAL_IO       = dummy_of(DUMMY_DUAL_IO_TBL, dc_reg);
	assign O_DUMMY_QUAD_IO       = dummy_of(DUMMY_QUAD_IO_TBL, dc_reg);
	assign O_ADDR_WIDTH_FLAG     = aw_reg;
	assign O_PROTECT_AREA_ORIGIN = origin_reg;
	assign O_STATUS              = status;

endmodule
`default_nettype wire

// file: tb/fcs_host_model.sv
// host controller model on the serial link of the flash block
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model (
	// serial link towards the device
	output var logic o_sclk,
	output var logic o_cs_n,
	output var logic o_si,
	input  wire logic i_so
);
	// idle: clock parked low, select high
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	task automatic xfer(input logic [23:0] d, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		#37 o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_si = d[23 - i];
			#80 o_sclk = 1'b1;
			if (i >= 8 && i < 16) rd = {rd[6:0], i_so};
			#80 o_sclk = 1'b0;
		end
		#80 o_cs_n = 1'b1;
		// released line flips, never shows a stale bit
		o_si = ~o_si;
		#100;
	endtask
endmodule
`default_nettype wire

// file: tb/fcs_top_assertions.sv
// port-level checks for the flash configuration and status block
`timescale 1ns/1ps
`default_nettype none
module fcs_top_assertions
	import fcs_pkg::*;
(
	// clock, reset, link select
	input wire logic       I_CLOCK,
	input wire logic       I_RST_N,
	input wire logic       I_CS_N,
	input wire logic       I_IO2_PIN_N,
	input wire logic       O_SO_OE_N,
	// mode and area check
	input wire logic       I_QUAD_COMMAND_MODE,
	input wire logic       I_PE_REQ,
	input wire logic       O_PE_GRANT,
	input wire logic       O_PE_REFUSE,
	// register views
	input wire logic [2:0] O_DRIVE_STRENGTH_SEL,
	input wire logic [1:0] O_DUMMY_COUNT_SEL,
	input wire logic       O_PROTECT_AREA_ORIGIN,
	input wire logic [7:0] O_STATUS,
	input wire logic       O_HW_PROTECT_MODE,
	input wire logic       O_SW_PROTECT_MODE
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	// busy length, 8 bits since the cycle stays near 100
	logic [7:0] busy_cnt_reg;
	logic [7:0] busy_cnt_next;
	always_comb begin
		busy_cnt_next = O_STATUS[0] ? busy_cnt_reg + 8'h01 : 8'h00;
	end
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			busy_cnt_reg <= 8'h00;
		end else begin
			busy_cnt_reg <= busy_cnt_next;
		end
	end
	// end of a self-timed write
	sequence s_cycle_end;
		$fell(O_STATUS[0]);
	endsequence
	property p_hw_mode;
		O_HW_PROTECT_MODE |-> O_STATUS[7] && !O_STATUS[6]
			&& !I_QUAD_COMMAND_MODE;
	endproperty
	a_hw_mode: assert property (p_hw_mode)
		else $error("hardware mode without its cause");
	// pin reaches the mode logic through two flip-flops
	property p_sw_mode;
		O_SW_PROTECT_MODE == !O_HW_PROTECT_MODE && O_HW_PROTECT_MODE ==
			(O_STATUS[7] && !O_STATUS[6] && !I_QUAD_COMMAND_MODE &&
			!$past(I_IO2_PIN_N, 2));
	endproperty
	a_sw_mode: assert property (p_sw_mode)
		else $error("protect modes not exclusive");
	property p_lock_hold;
		O_HW_PROTECT_MODE |=> $stable(O_STATUS[7:2]);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("protection bits moved in hardware mode");
	property p_busy_start;
		$rose(O_STATUS[0]) |-> I_CS_N && $past(O_STATUS[1]);
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("write cycle without latch or select");
	property p_busy_time;
		s_cycle_end |-> busy_cnt_reg >= STATUS_WRITE_CYC - 2
			&& busy_cnt_reg <= STATUS_WRITE_CYC + 2;
	endproperty
	a_busy_time: assert property (p_busy_time)
		else $error("write cycle length wrong");
	property p_latch_end;
		s_cycle_end |-> !O_STATUS[1];
	endproperty
	a_latch_end: assert property (p_latch_end)
		else $error("latch left set after write cycle");
	property p_cfg_end;
		$changed({O_DRIVE_STRENGTH_SEL, O_DUMMY_COUNT_SEL,
			O_PROTECT_AREA_ORIGIN}) |-> s_cycle_end;
	endproperty
	a_cfg_end: assert property (p_cfg_end)
		else $error("configuration changed outside a write");
	property p_origin;
		O_PROTECT_AREA_ORIGIN |=> O_PROTECT_AREA_ORIGIN;
	endproperty
	a_origin: assert property (p_origin)
		else $error("origin bit returned to zero");
	property p_pe_answer;
		I_PE_REQ |=> O_PE_GRANT != O_PE_REFUSE;
	endproperty
	a_pe_answer: assert property (p_pe_answer)
		else $error("area check without one answer");
	property p_pe_quiet;
		!I_PE_REQ |=> !O_PE_GRANT && !O_PE_REFUSE;
	endproperty
	a_pe_quiet: assert property (p_pe_quiet)
		else $error("area answer without request");
	property p_oe_idle;
		I_CS_N [*2] |-> O_SO_OE_N;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("output driven while deselected");
endmodule
bind fcs_top fcs_top_assertions chk_u (
	.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N),
	.I_IO2_PIN_N(I_IO2_PIN_N),
	.O_SO_OE_N(O_SO_OE_N), .I_QUAD_COMMAND_MODE(I_QUAD_COMMAND_MODE),
	.I_PE_REQ(I_PE_REQ), .O_PE_GRANT(O_PE_GRANT),
	.O_PE_REFUSE(O_PE_REFUSE), .O_DRIVE_STRENGTH_SEL(O_DRIVE_STRENGTH_SEL),
	.O_DUMMY_COUNT_SEL(O_DUMMY_COUNT_SEL), .O_STATUS(O_STATUS),
	.O_PROTECT_AREA_ORIGIN(O_PROTECT_AREA_ORIGIN),
	.O_HW_PROTECT_MODE(O_HW_PROTECT_MODE),
	.O_SW_PROTECT_MODE(O_SW_PROTECT_MODE));
`default_nettype wire

// file: tb/fcs_top_tb_top.sv
// self-checking bench for the flash configuration and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end \
end
module fcs_top_tb_top;
	import fcs_pkg::*;
	// bench pins
	logic       i_clock, i_rst_n, i_io2_pin_n, i_quad_cmd, i_pe_req;
	logic       sclk, cs_n, si, so, pe_grant, pe_refuse, aw, origin, hw, sw;
	logic [3:0] pe_block, d_fast, d_dual, d_quad;
	logic [2:0] drive_strength_sel;
	logic [1:0] dc;
	logic [7:0] status, cfg_v;
	int         error_cnt, comparisons, cyc_cnt;
	assign cfg_v = {dc, aw, 1'b0, origin, drive_strength_sel};
	// small block count keeps the area check short
	fcs_top #(.BLK_W(4)) dut_u (.I_CLOCK(i_clock), .I_RST_N(i_rst_n),
		.I_SCLK(sclk), .I_CS_N(cs_n), .I_SI(si), .O_SO(so), .O_SO_OE_N(),
		.I_IO2_PIN_N(i_io2_pin_n), .I_QUAD_COMMAND_MODE(i_quad_cmd),
		.I_PE_REQ(i_pe_req), .I_PE_BLOCK(pe_block), .O_PE_GRANT(pe_grant),
		.O_PE_REFUSE(pe_refuse), .O_DRIVE_STRENGTH_SEL(drive_strength_sel),
		.O_DUMMY_COUNT_SEL(dc), .O_DUMMY_FAST(d_fast),
		.O_DUMMY_DUAL_IO(d_dual), .O_DUMMY_QUAD_IO(d_quad),
		.O_ADDR_WIDTH_FLAG(aw), .O_PROTECT_AREA_ORIGIN(origin),
		.O_STATUS(status), .O_HW_PROTECT_MODE(hw), .O_SW_PROTECT_MODE(sw));
	fcs_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
		.i_so(so));
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		host_u.xfer({op, 16'h0000}, 8, r);
		cyc(6);
	endtask
	// bounded wait for the self-timed write
	task automatic idle;
		cyc(6);
		for (int k = 0; k < 300 && status[0] !== 1'b0; k++) cyc(1);
		`CHK("busy", 1'b0, status[0])
	endtask
	task automatic wsr(input logic [15:0] d, input int n);
		logic [7:0] r;
		cmd(OP_WRITE_ENABLE);
		host_u.xfer({OP_WRITE_STATUS, d}, n, r);
		idle;
	endtask
	task automatic t_reset;
		logic [7:0] r;
		`CHK("status", 8'h00, status)
		`CHK("config", 8'h07, cfg_v)
		`CHK("soft mode", 1'b1, sw)
		host_u.xfer({OP_READ_CONFIG, 16'h0000}, 16, r);
		`CHK("read config", 8'h07, r & 8'hef)
	endtask
	task automatic t_wide;
		cmd(OP_ENTER_WIDE);
		`CHK("wide on", 1'b1, aw)
		cmd(OP_EXIT_WIDE);
		`CHK("wide off", 1'b0, aw)
		cmd(OP_ENTER_WIDE);
		i_rst_n = 1'b0;
		cyc(3);
		i_rst_n = 1'b1;
		cyc(4);
		`CHK("wide reset", 1'b0, aw)
	endtask
	task automatic t_wrsr16;
		logic [7:0] r;
		cmd(OP_WRITE_ENABLE);
		`CHK("latch", 8'h02, status)
		host_u.xfer({OP_WRITE_STATUS, 16'h3fcd}, 24, r);
		cyc(1);
		`CHK("in cycle", 1'b1, status[0])
		idle;
		`CHK("status", 8'h3c, status)
		`CHK("config", 8'hcd, cfg_v)
		host_u.xfer({OP_READ_STATUS, 16'h0000}, 16, r);
		`CHK("read status", 8'h3c, r)
	endtask
	// every drive and dummy code; origin written 0 must stay 1
	task automatic t_codes;
		logic [3:0] f_t[4] = '{4'h8, 4'h6, 4'h8, 4'ha};
		logic [3:0] d_t[4] = '{4'h4, 4'h6, 4'h8, 4'ha};
		logic [3:0] q_t[4] = '{4'h6, 4'h4, 4'h8, 4'ha};
		for (int k = 0; k < 8; k++) begin
			wsr({8'h04, 2'(k), 3'h0, 3'(k)}, 24);
			`CHK("drive", 3'(k), drive_strength_sel)
			`CHK("origin", 1'b1, origin)
			`CHK("fast", f_t[k % 4], d_fast)
			`CHK("dual io", d_t[k % 4], d_dual)
			`CHK("quad io", q_t[k % 4], d_quad)
		end
	endtask
	task automatic t_reject;
		logic [7:0] r;
		cmd(OP_WRITE_ENABLE);
		host_u.xfer({OP_WRITE_STATUS, 16'hfff0}, 20, r);
		cyc(12);
		`CHK("odd length", 8'h06, status)
		host_u.xfer({OP_WRITE_STATUS, 16'h0800}, 16, r);
		idle;
		`CHK("one byte", 8'h08, status)
		`CHK("config kept", 8'hcf, cfg_v)
		host_u.xfer({OP_WRITE_STATUS, 16'h3c00}, 16, r);
		cyc(12);
		`CHK("no latch", 8'h08, status)
	endtask
	task automatic t_hpm;
		wsr(16'h8800, 16);
		`CHK("lock", 8'h88, status)
		i_io2_pin_n = 1'b0;
		cyc(4);
		`CHK("hard mode", 1'b1, hw)
		wsr(16'h0000, 16);
		`CHK("refused", 8'h8a, status)
		i_quad_cmd = 1'b1;
		cyc(1);
		`CHK("quad lifts", 1'b0, hw)
		i_quad_cmd = 1'b0;
		cyc(1);
		`CHK("still hard", 1'b1, hw)
		// pin raised after the refused write lifts hardware mode
		i_io2_pin_n = 1'b1;
		cyc(4);
		`CHK("pin lifts", 1'b0, hw)
		wsr(16'h0400, 16);
		`CHK("unlocked", 8'h04, status)
	endtask
	// back to back checks, one level protects block 0 at the bottom
	task automatic t_pe;
		logic [3:0] blk[3] = '{4'h0, 4'h1, 4'hf};
		for (int k = 0; k < 3; k++) begin
			pe_block = blk[k];
			i_pe_req = 1'b1;
			cyc(1);
			`CHK("refuse", k == 0, pe_refuse)
			`CHK("grant", k != 0, pe_grant)
		end
		i_pe_req = 1'b0;
		// reset clears the modelled origin; one level then guards the top
		i_rst_n = 1'b0;
		cyc(3);
		i_rst_n = 1'b1;
		cyc(4);
		wsr(16'h0400, 16);
		`CHK("origin top", 1'b0, origin)
		pe_block = 4'hf;
		i_pe_req = 1'b1;
		cyc(1);
		`CHK("refuse top", 1'b1, pe_refuse)
		`CHK("grant top", 1'b0, pe_grant)
		i_pe_req = 1'b0;
	endtask
	task automatic close_out;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// main sequence
	initial begin
		i_rst_n = 1'b0;
		i_io2_pin_n = 1'b1;
		i_quad_cmd = 1'b0;
		i_pe_req = 1'b0;
		pe_block = 4'h0;
		error_cnt = 0;
		comparisons = 0;
		cyc(3);
		i_rst_n = 1'b1;
		cyc(4);
		t_reset;
		t_wide;
		t_wrsr16;
		t_codes;
		t_reject;
		t_hpm;
		t_pe;
		close_out;
	end
	// ceiling well above the roughly 10000 cycles of the run
	initial cyc_cnt = 0;
	always @(posedge i_clock) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			error_cnt++;
			close_out;
		end
	end
endmodule
`default_nettype wire
